// File: hdl/rct_refresh_timer.sv
// refresh controller and interval timer for memory area 3
//
// Our own choices: strobed register access and the placing of the registers.
`include "rct_params.svh"
module rct_refresh_timer (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       sw_standby_i,
    input  wire logic       hw_standby_i,
    input  wire logic       ext_req_i,
    input  wire logic       dma_req_i,
    input  wire logic       wait_i,
    output logic            ext_gnt_o,
    output logic            dma_gnt_o,
    output logic            cpu_gnt_o,
    output logic            compare_irq_o,
    output logic            area3_select_n_o,
    output logic            refresh_strobe_n_o,
    output logic            upper_write_strobe_n_o,
    output logic            lower_write_strobe_n_o,
    output logic            read_strobe_n_o,
    output logic            strobe_oe_o
);
    rct_tick_if tk ();

    logic [7:0]          refresh_control;
    logic [7:0]          timer_control_status;
    logic [7:0]          refresh_timer_count;
    logic [7:0]          refresh_time_constant;
    rct_pkg::rct_state_t state;
    logic [1:0]          ref_cnt;
    logic                match_seen;
    rct_pkg::rct_grant_t grant;

    wire mem_en      = refresh_control[`RCT_BIT_DRAM_EN] | refresh_control[`RCT_BIT_PSRAM_EN];
    wire self_ref    = refresh_control[`RCT_BIT_SELF_REF];
    wire psram       = refresh_control[`RCT_BIT_PSRAM_EN];
    wire dram        = refresh_control[`RCT_BIT_DRAM_EN] & ~psram;
    wire col_mode    = refresh_control[`RCT_BIT_STROBE_MODE];
    wire run         = ~hw_standby_i & ~sw_standby_i;
    wire cfg_lock    = mem_en;
    wire wr_ctrl     = wr_i & (addr_i == `RCT_OFS_CONTROL) & ~cfg_lock & run;
    wire wr_stat     = wr_i & (addr_i == `RCT_OFS_STATUS) & ~cfg_lock & run;
    wire wr_cnt      = wr_i & (addr_i == `RCT_OFS_COUNT) & run;
    wire wr_const    = wr_i & (addr_i == `RCT_OFS_CONSTANT) & ~cfg_lock & run;
    wire at_match    = (refresh_timer_count == refresh_time_constant);
    // match pulse on leaving the matching value; suppressed by a constant write
    wire match_pulse = tk.tick & run & at_match & ~wr_const;
    wire counter_clr = tk.tick & run & at_match;
    wire req         = match_pulse & mem_en;
    wire flag_clr    = wr_stat & ~wdata_i[`RCT_BIT_FLAG];
    wire in_cycle    = (state == rct_pkg::RCT_CYCLE);
    wire ref_req_bus = (state == rct_pkg::RCT_REQUEST);
    // wait states stretch the refresh cycle only in a three-state area
    wire stretch     = refresh_control[`RCT_BIT_AREA3_3ST] & wait_i;
    wire cycle_last  = in_cycle & ~stretch & (ref_cnt == `RCT_REF_STATES - 2'h1);

    assign tk.clock_select = timer_control_status[`RCT_CKS_HI:`RCT_CKS_LO];
    assign tk.run          = run;

    rct_prescaler #(.PRESC_W(13)) u_presc (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .tk     (tk)
    );

    // fixed bus priority
    rct_pkg::rct_grant_t next_grant;
    // a running refresh cycle keeps the bus until its last state
    assign next_grant = in_cycle    ? rct_pkg::RCT_GNT_REF :
                        ext_req_i   ? rct_pkg::RCT_GNT_EXT :
                        ref_req_bus ? rct_pkg::RCT_GNT_REF :
                        dma_req_i   ? rct_pkg::RCT_GNT_DMA : rct_pkg::RCT_GNT_NONE;

    logic [7:0] next_rdata;
    always_comb begin
        if (addr_i == `RCT_OFS_CONTROL) begin
            next_rdata = refresh_control;
        end else if (addr_i == `RCT_OFS_STATUS) begin
            next_rdata = timer_control_status;
        end else if (addr_i == `RCT_OFS_COUNT) begin
            next_rdata = refresh_timer_count;
        end else if (addr_i == `RCT_OFS_CONSTANT) begin
            next_rdata = refresh_time_constant;
        end else if (addr_i == `RCT_OFS_ARB) begin
            next_rdata = {4'h0, in_cycle, state == rct_pkg::RCT_PENDING, grant};
        end else begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? next_rdata : 8'h00;
        end
    end

    // configuration kept through software standby
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            refresh_control       <= `RCT_RST_CONTROL;
            refresh_time_constant <= `RCT_RST_CONSTANT;
        end else begin
            if (wr_ctrl) begin
                refresh_control <= wdata_i;
            end
            if (wr_const) begin
                refresh_time_constant <= wdata_i;
            end
        end
    end

    // status: flag set wins over clear; software standby clears flag and enable
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            timer_control_status <= `RCT_RST_STATUS;
        end else if (sw_standby_i && !hw_standby_i) begin
            timer_control_status[`RCT_BIT_FLAG]   <= 1'b0;
            timer_control_status[`RCT_BIT_IRQ_EN] <= 1'b0;
        end else begin
            if (wr_stat) begin
                timer_control_status[`RCT_BIT_IRQ_EN]         <= wdata_i[`RCT_BIT_IRQ_EN];
                timer_control_status[`RCT_CKS_HI:`RCT_CKS_LO] <= wdata_i[`RCT_CKS_HI:`RCT_CKS_LO];
            end
            if (match_pulse) begin
                timer_control_status[`RCT_BIT_FLAG] <= 1'b1;
            end else if (flag_clr) begin
                timer_control_status[`RCT_BIT_FLAG] <= 1'b0;
            end
        end
    end

    // counter: clear beats write, write beats increment
    always_ff @(posedge clk_i) begin
        if (srst_i || sw_standby_i) begin
            refresh_timer_count <= 8'h00;
        end else if (hw_standby_i) begin
            refresh_timer_count <= refresh_timer_count;
        end else if (counter_clr) begin
            refresh_timer_count <= 8'h00;
        end else if (wr_cnt) begin
            refresh_timer_count <= wdata_i;
        end else if (tk.tick) begin
            refresh_timer_count <= refresh_timer_count + 8'h01;
        end
    end

    // refresh sequencer, same for DRAM and pseudo-static
    rct_pkg::rct_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            rct_pkg::RCT_IDLE: begin
                if (req) begin
                    next_state = rct_pkg::RCT_PENDING;
                end
            end
            rct_pkg::RCT_PENDING: begin
                if (req && refresh_control[`RCT_BIT_RCYC_EN]) begin
                    next_state = rct_pkg::RCT_REQUEST;
                end
            end
            rct_pkg::RCT_REQUEST: begin
                if (next_grant == rct_pkg::RCT_GNT_REF) begin
                    next_state = rct_pkg::RCT_CYCLE;
                end
            end
            rct_pkg::RCT_CYCLE: begin
                // requests during the cycle are dropped
                if (cycle_last) begin
                    next_state = rct_pkg::RCT_PENDING;
                end
            end
            default: begin
                next_state = rct_pkg::RCT_IDLE;
            end
        endcase
    end

    // state counter of the refresh cycle, held while stretched
    logic [1:0] next_ref_cnt;
    always_comb begin
        next_ref_cnt = 2'h0;
        if (in_cycle && !stretch && !cycle_last) begin
            next_ref_cnt = ref_cnt + 2'h1;
        end else if (in_cycle) begin
            next_ref_cnt = ref_cnt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || sw_standby_i || hw_standby_i || !mem_en) begin
            state   <= rct_pkg::RCT_IDLE;
            ref_cnt <= 2'h0;
        end else begin
            state   <= next_state;
            ref_cnt <= next_ref_cnt;
        end
    end

    // pin levels (active low strobes)
    logic next_area3;
    logic next_refresh_strobe;
    logic next_upper;
    logic next_lower;
    logic next_read;
    logic next_oe;
    always_comb begin
        next_area3 = 1'b1;
        next_refresh_strobe  = 1'b1;
        next_upper = 1'b1;
        next_lower = 1'b1;
        next_read  = 1'b1;
        next_oe    = 1'b1;
        if (hw_standby_i) begin
            next_oe = 1'b0;
        end else if (sw_standby_i && dram && self_ref) begin
            next_area3 = 1'b0;
            next_refresh_strobe  = 1'b0;
            next_upper = col_mode ? 1'b0 : 1'b1;
            next_lower = col_mode ? 1'b0 : 1'b1;
            next_read  = col_mode ? 1'b1 : 1'b0;
        end else if (sw_standby_i) begin
            next_oe   = 1'b0;
            next_refresh_strobe = ~(psram & self_ref);
        end else if (in_cycle) begin
            next_refresh_strobe = 1'b0;
            if (dram) begin
                // column strobe before row strobe
                next_read  = col_mode;
                next_upper = ~col_mode;
                next_lower = ~col_mode;
                next_area3 = (ref_cnt == 2'h0);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            area3_select_n_o       <= 1'b1;
            refresh_strobe_n_o     <= 1'b1;
            upper_write_strobe_n_o <= 1'b1;
            lower_write_strobe_n_o <= 1'b1;
            read_strobe_n_o        <= 1'b1;
            strobe_oe_o            <= 1'b1;
        end else begin
            area3_select_n_o       <= next_area3;
            refresh_strobe_n_o     <= next_refresh_strobe;
            upper_write_strobe_n_o <= next_upper;
            lower_write_strobe_n_o <= next_lower;
            read_strobe_n_o        <= next_read;
            strobe_oe_o            <= next_oe;
        end
    end

    // bus grants
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            grant     <= rct_pkg::RCT_GNT_NONE;
            ext_gnt_o <= 1'b0;
            dma_gnt_o <= 1'b0;
            cpu_gnt_o <= 1'b0;
        end else begin
            grant     <= next_grant;
            ext_gnt_o <= next_grant == rct_pkg::RCT_GNT_EXT;
            dma_gnt_o <= next_grant == rct_pkg::RCT_GNT_DMA;
            cpu_gnt_o <= next_grant == rct_pkg::RCT_GNT_NONE;
        end
    end

    // interval timer interrupt only with both memory enables clear
    wire irq_level = ~mem_en & timer_control_status[`RCT_BIT_FLAG] & timer_control_status[`RCT_BIT_IRQ_EN];
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            compare_irq_o <= 1'b0;
        end else begin
            compare_irq_o <= irq_level;
        end
    end
endmodule

// File: hdl/rct_params.svh
// register offsets, field positions, reset values and timing counts of the refresh timer
`ifndef RCT_PARAMS_SVH
`define RCT_PARAMS_SVH
`define RCT_OFS_CONTROL      4'h0
`define RCT_OFS_STATUS       4'h1
`define RCT_OFS_COUNT        4'h2
`define RCT_OFS_CONSTANT     4'h3
`define RCT_OFS_ARB          4'h4
`define RCT_BIT_FLAG         7
`define RCT_BIT_IRQ_EN       6
`define RCT_CKS_HI           5
`define RCT_CKS_LO           3
`define RCT_BIT_SELF_REF     7
`define RCT_BIT_PSRAM_EN     6
`define RCT_BIT_DRAM_EN      5
`define RCT_BIT_STROBE_MODE  4
`define RCT_BIT_AREA3_3ST    3
`define RCT_BIT_RCYC_EN      2
`define RCT_RST_CONTROL      8'h00
`define RCT_RST_STATUS       8'h07
`define RCT_RST_CONSTANT     8'hFF
`define RCT_REF_STATES       2'h3
`endif

// File: hdl/rct_pkg.sv
// types shared by the refresh timer modules
package rct_pkg;
    typedef enum logic [1:0] {
        RCT_IDLE    = 2'b00,
        RCT_PENDING = 2'b01,
        RCT_REQUEST = 2'b10,
        RCT_CYCLE   = 2'b11
    } rct_state_t;

    typedef enum logic [1:0] {
        RCT_GNT_NONE = 2'b00,
        RCT_GNT_EXT  = 2'b01,
        RCT_GNT_REF  = 2'b10,
        RCT_GNT_DMA  = 2'b11
    } rct_grant_t;
endpackage

// File: hdl/rct_tick_if.sv
// tap select, run and selected-clock counter pulse between the timer and its prescaler
interface rct_tick_if;
    logic [2:0] clock_select;
    logic       run;
    logic       tick;

    modport timer (output clock_select, output run, input tick);
    modport presc (input clock_select, input run, output tick);
endinterface

// File: hdl/rct_prescaler.sv
// prescaler: selected internal clock level and falling-edge counter pulse
module rct_prescaler #(
    parameter int PRESC_W = 13
) (
    input  wire logic  clk_i,
    input  wire logic  srst_i,
    rct_tick_if.presc  tk
);
    logic [PRESC_W-1:0] div;
    logic [7:0]         taps;
    logic               sel_level;
    logic               sel_level_d;
    logic               tick;

    // source 0 is halted and reads low; others are divider bits
    assign taps      = {div[12], div[10], div[8], div[6], div[4], div[2], div[0], 1'b0};
    assign sel_level = tk.run & taps[tk.clock_select];
    // a switch from a high source to a low one also reads as a fall
    assign tick      = sel_level_d & ~sel_level;
    assign tk.tick   = tick;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            div         <= '0;
            sel_level_d <= 1'b0;
        end else begin
            div         <= div + 1'b1;
            sel_level_d <= sel_level;
        end
    end
endmodule

// File: tb/rct_refresh_timer_sva.sv
// concurrent checks on the refresh timer ports
module rct_refresh_timer_sva (
    input wire logic       clk_i,
    input wire logic       srst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       sw_standby_i,
    input wire logic       hw_standby_i,
    input wire logic       ext_req_i,
    input wire logic       dma_req_i,
    input wire logic       wait_i,
    input wire logic       ext_gnt_o,
    input wire logic       dma_gnt_o,
    input wire logic       cpu_gnt_o,
    input wire logic       compare_irq_o,
    input wire logic       area3_select_n_o,
    input wire logic       refresh_strobe_n_o,
    input wire logic       upper_write_strobe_n_o,
    input wire logic       lower_write_strobe_n_o,
    input wire logic       read_strobe_n_o,
    input wire logic       strobe_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // refresh cycle start outside standby, not stretched
    sequence ref_start_s;
        $fell(refresh_strobe_n_o) && !sw_standby_i && !hw_standby_i && !wait_i;
    endsequence
    sequence ref_end_s;
        ##[1:8] refresh_strobe_n_o;
    endsequence
    grant_onehot_a: assert property ($onehot0({ext_gnt_o, dma_gnt_o, cpu_gnt_o}))
        else $error("more than one bus grant");
    ext_first_a: assert property (dma_gnt_o |-> !$past(ext_req_i))
        else $error("dma granted over external master");
    cpu_last_a: assert property (cpu_gnt_o |-> !$past(ext_req_i) && !$past(dma_req_i))
        else $error("cpu granted over another requester");
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read answer cycle");
    irq_standby_a: assert property (sw_standby_i [*3] |-> !compare_irq_o)
        else $error("interrupt kept in software standby");
    hw_quiet_a: assert property (hw_standby_i [*2] |-> !strobe_oe_o)
        else $error("strobes driven in hardware standby");
    ref_release_a: assert property ($fell(sw_standby_i) |-> ##[1:4] refresh_strobe_n_o)
        else $error("refresh strobe not released after standby");
    ref_length_a: assert property (ref_start_s |-> ref_end_s)
        else $error("refresh cycle too long without wait");
endmodule
bind rct_refresh_timer rct_refresh_timer_sva u_sva (.*);

// File: tb/rct_mem_model.sv
// area 3 memory stand-in: counts refresh cycles on its strobes
module rct_mem_model (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic refresh_n_i,
    input  wire logic oe_i,
    output int        refresh_count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_n;
    always @(posedge clk_i) begin
        last_n <= refresh_n_i;
        if (srst_i) begin
            refresh_count_o <= 0;
        end else if (oe_i && last_n && !refresh_n_i) begin
            refresh_count_o <= refresh_count_o + 1;
        end
    end
endmodule

// File: tb/tb_top.sv
// self-checking bench for the refresh timer
`include "rct_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_i, srst_i, wr_i, rd_i, sw_standby_i, hw_standby_i, ext_req_i, dma_req_i, wait_i;
    logic [3:0] addr_i;
    logic [7:0] wdata_i, rdata_o, cfg [4], v, w;
    logic       ext_gnt_o, dma_gnt_o, cpu_gnt_o, compare_irq_o, area3_n, refresh_n, upper_n, lower_n, read_n, oe;
    logic [2:0] pin_exp [4], wr_exp [4];
    logic       ok;
    int         cmp_count, n_mismatch, cyc, nref, t0, t1;
    rct_refresh_timer u_dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .sw_standby_i(sw_standby_i), .hw_standby_i(hw_standby_i),
        .ext_req_i(ext_req_i), .dma_req_i(dma_req_i), .wait_i(wait_i), .ext_gnt_o(ext_gnt_o),
        .dma_gnt_o(dma_gnt_o), .cpu_gnt_o(cpu_gnt_o), .compare_irq_o(compare_irq_o),
        .area3_select_n_o(area3_n), .refresh_strobe_n_o(refresh_n), .upper_write_strobe_n_o(upper_n),
        .lower_write_strobe_n_o(lower_n), .read_strobe_n_o(read_n), .strobe_oe_o(oe));
    rct_mem_model u_mem (.clk_i(clk_i), .srst_i(srst_i), .refresh_n_i(refresh_n), .oe_i(oe),
        .refresh_count_o(nref));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask
    task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(nm, d, exp);
    endtask
    task automatic do_reset(input int n);
        srst_i <= 1'b1;
        repeat (n) @(posedge clk_i);
        srst_i <= 1'b0;
    endtask
    // poll a register until a masked bit is set, bounded
    task automatic poll(input logic [3:0] a, input logic [7:0] m, output logic hit);
        logic [7:0] d;
        hit = 1'b0;
        for (int i = 0; i < 100 && !hit; i++) begin
            rd(a, d);
            hit = |(d & m);
        end
    endtask
    // wait for a fresh rise of the interrupt, bounded
    task automatic wait_irq(output int t);
        for (int i = 0; i < 100 && compare_irq_o !== 1'b0; i++) @(negedge clk_i);
        for (int i = 0; i < 100 && compare_irq_o !== 1'b1; i++) @(negedge clk_i);
        t = cyc;
    endtask
    task automatic standby(input logic lvl);
        @(posedge clk_i);
        sw_standby_i <= lvl;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    initial begin
        {wr_i, rd_i, sw_standby_i, hw_standby_i, ext_req_i, dma_req_i, wait_i} = '0;
        srst_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        cfg = '{8'hA4, 8'hB4, 8'hC4, 8'h4C};
        pin_exp = '{3'b001, 3'b001, 3'b100, 3'b110};
        wr_exp = '{3'b110, 3'b001, 3'b000, 3'b000};
        do_reset(16);
        rchk("control reset", `RCT_OFS_CONTROL, 8'h00);
        rchk("status reset", `RCT_OFS_STATUS, 8'h07);
        rchk("constant reset", `RCT_OFS_CONSTANT, 8'hFF);
        rchk("count reset", `RCT_OFS_COUNT, 8'h00);
        rchk("unmapped", 4'hF, 8'h00);
        wr(`RCT_OFS_CONSTANT, 8'h03);
        wr(`RCT_OFS_STATUS, 8'h48);
        poll(`RCT_OFS_STATUS, 8'h80, ok);
        chk("flag set", 8'(ok), 8'h01);
        wr(`RCT_OFS_STATUS, 8'h48);
        wait_irq(t0);
        wr(`RCT_OFS_STATUS, 8'h48);
        wait_irq(t1);
        chk("match interval", 8'(t1 - t0), 8'h08);
        standby(1'b1);
        chk("irq in standby", 8'(compare_irq_o), 8'h00);
        rchk("status standby", `RCT_OFS_STATUS, 8'h0F);
        rchk("constant standby", `RCT_OFS_CONSTANT, 8'h03);
        rchk("count standby", `RCT_OFS_COUNT, 8'h00);
        standby(1'b0);
        @(posedge clk_i);
        hw_standby_i <= 1'b1;
        rd(`RCT_OFS_COUNT, v);
        repeat (20) @(posedge clk_i);
        rd(`RCT_OFS_COUNT, w);
        chk("count frozen", w, v);
        chk("hw float", 8'(oe), 8'h00);
        @(posedge clk_i);
        hw_standby_i <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i);
            ext_req_i <= (k == 0);
            dma_req_i <= (k != 2);
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            chk("grants", {5'h00, ext_gnt_o, dma_gnt_o, cpu_gnt_o}, 8'h04 >> k);
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            {ext_req_i, dma_req_i} <= 2'b00;
            do_reset(2);
            wr(`RCT_OFS_CONSTANT, 8'h03);
            wr(`RCT_OFS_STATUS, 8'h08);
            wr(`RCT_OFS_CONTROL, cfg[k]);
            wr(`RCT_OFS_CONSTANT, 8'h20);
            rchk("locked constant", `RCT_OFS_CONSTANT, 8'h03);
            poll(`RCT_OFS_ARB, 8'h04, ok);
            chk("pending", {7'h00, ok}, 8'h01);
            chk("first request", 8'(nref), 8'h00);
            @(posedge clk_i);
            wait_i <= (k == 3);
            repeat (29) @(posedge clk_i);
            @(negedge clk_i);
            chk("refreshed", 8'(nref != 0), 8'h01);
            if (k == 3) chk("wait stretch", 8'(refresh_n), 8'h00);
            standby(1'b1);
            chk("standby pins", {5'h00, area3_n, refresh_n, oe}, {5'h00, pin_exp[k]});
            if (pin_exp[k][0]) chk("standby strobes", {5'h00, upper_n, lower_n, read_n}, {5'h00, wr_exp[k]});
            standby(1'b0);
            chk("refresh released", 8'(refresh_n), 8'h01);
        end
        summarize();
    end
endmodule
